// file: pkg/spc_pkg.sv
// constants and types shared by the sleep power controller
`default_nettype none
package spc_pkg;
    localparam logic [31:0] SPC_GATE_ADDR = 32'h4000_4038;
    localparam logic [31:0] SPC_CTRL_ADDR = 32'h4000_403C;
    localparam logic [31:0] SPC_STAT_ADDR = 32'h4000_4040;
    localparam logic [31:0] SPC_GATE_RST = 32'h0000_0000;
    localparam int SPC_GATE_W = 6;
    localparam int SPC_PERIPH_N = 5;
    localparam int SPC_GATE_RSVD = 5;
    localparam int SPC_CTRL_W = 2;
    localparam int SPC_CTRL_DS2 = 0;
    localparam int SPC_CTRL_XTAL = 1;
    localparam int SPC_STAT_SYS = 6;
    localparam int SPC_STAT_DBG = 7;
    localparam int SPC_STAT_DS2 = 8;
    localparam int SPC_SYNC_W = 6;
    localparam int SPC_SY_SYS = 0;
    localparam int SPC_SY_DBG = 1;
    localparam int SPC_SY_GPIO = 2;
    localparam int SPC_SY_TMR = 3;
    localparam int SPC_CLK_NS = 100;
    localparam int SPC_SETTLE_NS = 1000;
    localparam logic [3:0] SPC_SETTLE_CYC = 4'((SPC_SETTLE_NS + SPC_CLK_NS - 1) / SPC_CLK_NS);
    localparam logic [3:0] SPC_CNT_ZERO = 4'h0;
    localparam logic [3:0] SPC_CNT_ONE = 4'h1;
    typedef enum logic [5:0] {
        SPC_RUN = 6'h01,
        SPC_IDLE = 6'h02,
        SPC_PRE = 6'h04,
        SPC_DEEP = 6'h08,
        SPC_EMU = 6'h10,
        SPC_WAKE = 6'h20
    } spc_state_e;
endpackage
`default_nettype wire

// file: pkg/spc_reg_if.sv
// register strobe carrier between bus slave and controller core
`timescale 1ns/1ns
`default_nettype none
interface spc_reg_if;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic [31:0] rdata;
    logic hit;
    modport slave (output addr, output wdata, output wr_stb, input rdata, input hit);
    modport core (input addr, input wdata, input wr_stb, output rdata, output hit);
endinterface
`default_nettype wire

// file: rtl/spc_sync.sv
// two-flop synchroniser for pin and foreign-clock levels
`timescale 1ns/1ns
`default_nettype none
module spc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spc_sync_s;
    spc_sync_s st_r;
    spc_sync_s st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule // spc_sync
`default_nettype wire

// file: rtl/spc_apb.sv
// apb slave: no wait states, error on unmapped address
`timescale 1ns/1ns
`default_nettype none
module spc_apb (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    spc_reg_if.slave rif
);
    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic err;
    } spc_apb_s;
    spc_apb_s st_r;
    spc_apb_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // answer is prepared during setup so it can be held stable in access
        st_nxt.ready = psel && !penable;
        if (psel && !penable) begin
            st_nxt.rdata = rif.hit ? rif.rdata : 32'h0000_0000;
            st_nxt.err = !rif.hit;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rif.addr = paddr;
    assign rif.wdata = pwdata;
    assign rif.wr_stb = psel && penable && pwrite && st_r.ready && !st_r.err;
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.err;
endmodule // spc_apb
`default_nettype wire

// file: rtl/spc_ctrl.sv
// sleep power controller: sleep sequencing and peripheral clock gating
`timescale 1ns/1ns
`default_nettype none
// Function
// - wait-for-interrupt with deep select clear enters idle sleep, core stays powered.
// - wait-for-interrupt with deep select set sequences into deep sleep, core off.
// - deep request first waits in pre-deep state, touching nothing while system request set.
// - deep sleep waits for wake, re-powers core, resets CPU, returns to running.
// - low-frequency RC oscillator runs through deep sleep by default, deep sleep 1.
// - deep sleep 2 stops RC oscillator; timers wake nothing unless crystal clocks them.
// - non-timer wakes work in deep sleep 2; any wake restarts the RC oscillator.
// - debug request set turns any deep request into emulated deep sleep 0.
// - emulated deep sleep 0 neither powers off nor resets the core domain.
// - system request set while awake blocks deep sleep entry until cleared.
// - true deep sleep only when both debug port requests are clear.
// - either request asserting wakes the chip from deep sleep.
// - debugger accesses during deep sleep are stalled until the core is ready.
// - the two requests change only by power-on reset or debugger command.
// - gate bits 4..0 stop clocks of converter, timer two, one, serial one, two.
// - gate register resets to zero; bits 31..6 read zero, reserved bit 5 reads back as written.
// - a gated peripheral ignores writes and keeps its values for reads.
// - in emulated deep sleep 0 all peripherals except debug parts are reset.
// - sleep timer compare and wrap wake from deep sleep 0 and 1, and from deep sleep 2 only on crystal.
// - debugger write to the core wake bit wakes only from deep sleep 0.
module spc_ctrl
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wait_for_interrupt_instr,
    input wire logic deep_sleep_select,
    input wire logic irq_pending,
    input wire logic sys_power_up_request,
    input wire logic debug_power_up_request,
    input wire logic gpio_wake,
    input wire logic [2:0] sleep_timer_wake,
    input wire logic core_wake_write,
    output logic core_power_en,
    output logic cpu_reset,
    output logic periph_reset,
    output logic cpu_idle,
    output logic rc_osc_enable,
    output logic debug_stall,
    output logic [SPC_PERIPH_N-1:0] periph_clock_stop
);
    import spc_pkg::*;

    typedef struct packed {
        spc_state_e state;
        logic [3:0] cnt;
        logic [SPC_GATE_W-1:0] gate;
        logic [SPC_CTRL_W-1:0] ctrl;
        logic in_ds2;
        logic core_pwr;
        logic cpu_rst;
        logic per_rst;
        logic idle;
        logic rc_on;
        logic stall;
    } spc_core_s;

    spc_core_s st_r;
    spc_core_s st_nxt;
    spc_reg_if rif ();
    logic [SPC_SYNC_W-1:0] raw;
    logic [SPC_SYNC_W-1:0] sy;
    logic sys_req;
    logic dbg_req;
    logic timer_ev;
    logic base_wake;

    function automatic logic spc_sel(input logic [31:0] a, input logic [31:0] t);
        spc_sel = (a == t);
    endfunction

    // requests are never forced here; only the debug port moves them
    assign raw = {sleep_timer_wake, gpio_wake, debug_power_up_request, sys_power_up_request};

    spc_sync #(
        .W(SPC_SYNC_W)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .d(raw),
        .q(sy)
    );

    spc_apb u_apb (
        .clk(clk),
        .srst(srst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif.slave)
    );

    assign sys_req = sy[SPC_SY_SYS];
    assign dbg_req = sy[SPC_SY_DBG];
    assign timer_ev = |sy[SPC_SYNC_W-1:SPC_SY_TMR];
    // timer-independent wakes, plus either debug port request
    assign base_wake = sy[SPC_SY_GPIO] || sys_req || dbg_req;

    always_comb begin
        rif.hit = spc_sel(rif.addr, SPC_GATE_ADDR) || spc_sel(rif.addr, SPC_CTRL_ADDR)
            || spc_sel(rif.addr, SPC_STAT_ADDR);
        rif.rdata = 32'h0000_0000;
        if (spc_sel(rif.addr, SPC_GATE_ADDR)) begin
            rif.rdata[SPC_GATE_W-1:0] = st_r.gate;
        end else if (spc_sel(rif.addr, SPC_CTRL_ADDR)) begin
            rif.rdata[SPC_CTRL_W-1:0] = st_r.ctrl;
        end else if (spc_sel(rif.addr, SPC_STAT_ADDR)) begin
            rif.rdata[$bits(spc_state_e)-1:0] = st_r.state;
            rif.rdata[SPC_STAT_SYS] = sys_req;
            rif.rdata[SPC_STAT_DBG] = dbg_req;
            rif.rdata[SPC_STAT_DS2] = st_r.in_ds2;
        end
    end

    always_comb begin
        st_nxt = st_r;
        if (rif.wr_stb && spc_sel(rif.addr, SPC_GATE_ADDR)) begin
            // reserved bit is stored as written; software keeps its value
            st_nxt.gate = rif.wdata[SPC_GATE_W-1:0];
        end
        if (rif.wr_stb && spc_sel(rif.addr, SPC_CTRL_ADDR)) begin
            st_nxt.ctrl = rif.wdata[SPC_CTRL_W-1:0];
        end
        if (st_r.cnt != SPC_CNT_ZERO) begin
            st_nxt.cnt = st_r.cnt - SPC_CNT_ONE;
        end
        unique case (st_r.state)
            SPC_RUN: begin
                if (wait_for_interrupt_instr && !deep_sleep_select) begin
                    st_nxt.state = SPC_IDLE;
                end else if (wait_for_interrupt_instr) begin
                    st_nxt.state = SPC_PRE;
                end
            end
            SPC_IDLE: begin
                if (irq_pending) begin
                    st_nxt.state = SPC_RUN;
                end
            end
            SPC_PRE: begin
                // nothing is powered off or reset while waiting here
                if (sy[SPC_SY_GPIO] || timer_ev) begin
                    st_nxt.state = SPC_RUN;
                end else if (!sys_req && dbg_req) begin
                    st_nxt.state = SPC_EMU;
                end else if (!sys_req) begin
                    st_nxt.state = SPC_DEEP;
                    st_nxt.in_ds2 = st_r.ctrl[SPC_CTRL_DS2];
                end
            end
            SPC_DEEP: begin
                // with the rc stopped, timer events count only on crystal
                if (base_wake || (timer_ev
                    && (!st_r.in_ds2 || st_r.ctrl[SPC_CTRL_XTAL]))) begin
                    st_nxt.state = SPC_WAKE;
                    st_nxt.cnt = SPC_SETTLE_CYC;
                end
            end
            SPC_EMU: begin
                // debug request stays set here, so only gpio, timer, system request or core wake write wakes
                if (sy[SPC_SY_GPIO] || timer_ev || sys_req || core_wake_write) begin
                    st_nxt.state = SPC_RUN;
                end
            end
            SPC_WAKE: begin
                if (st_r.cnt == SPC_CNT_ONE) begin
                    st_nxt.state = SPC_RUN;
                    st_nxt.in_ds2 = 1'b0;
                end
            end
        endcase
        st_nxt.core_pwr = (st_nxt.state != SPC_DEEP);
        st_nxt.cpu_rst = (st_nxt.state == SPC_DEEP) || (st_nxt.state == SPC_WAKE);
        st_nxt.per_rst = st_nxt.cpu_rst || (st_nxt.state == SPC_EMU);
        st_nxt.idle = (st_nxt.state == SPC_IDLE);
        st_nxt.rc_on = !((st_nxt.state == SPC_DEEP) && st_nxt.in_ds2);
        st_nxt.stall = st_nxt.cpu_rst;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r.state <= SPC_RUN;
            st_r.cnt <= SPC_CNT_ZERO;
            st_r.gate <= SPC_GATE_RST[SPC_GATE_W-1:0];
            st_r.ctrl <= '0;
            st_r.in_ds2 <= 1'b0;
            st_r.core_pwr <= 1'b1;
            st_r.cpu_rst <= 1'b0;
            st_r.per_rst <= 1'b0;
            st_r.idle <= 1'b0;
            st_r.rc_on <= 1'b1;
            st_r.stall <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a stopped clock freezes the peripheral's registers as they stood
    genvar gi;
    generate
        for (gi = 0; gi < SPC_PERIPH_N; gi++) begin : g_stop
            assign periph_clock_stop[gi] = st_r.gate[gi];
        end
    endgenerate

    assign core_power_en = st_r.core_pwr;
    assign cpu_reset = st_r.cpu_rst;
    assign periph_reset = st_r.per_rst;
    assign cpu_idle = st_r.idle;
    assign rc_osc_enable = st_r.rc_on;
    assign debug_stall = st_r.stall;
endmodule // spc_ctrl
`default_nettype wire

// file: verification/spc_far_end.sv
// cpu core and debug port stand-in that drives the sleep controls
`timescale 1ns/1ns
`default_nettype none
module spc_far_end (
    input wire logic clk,
    input wire logic srst,
    input wire logic cpu_reset,
    input wire logic cpu_idle,
    input wire logic sleep_cmd,
    input wire logic deep_cmd,
    input wire logic txn,
    input wire logic txn_sys,
    input wire logic txn_dbg,
    output logic wait_for_interrupt_instr,
    output logic deep_sleep_select,
    output logic sys_power_up_request,
    output logic debug_power_up_request
);
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_for_interrupt_instr <= 1'h0;
            deep_sleep_select <= 1'h0;
            sys_power_up_request <= 1'h0;
            debug_power_up_request <= 1'h0;
        end else begin
            // a core in reset or idle executes nothing
            wait_for_interrupt_instr <= sleep_cmd && !cpu_reset && !cpu_idle;
            // select is only meaningful beside the pulse, so it wanders otherwise
            deep_sleep_select <= sleep_cmd ? deep_cmd : !deep_sleep_select;
            if (txn) begin
                sys_power_up_request <= txn_sys;
                debug_power_up_request <= txn_dbg;
            end
        end
    end
endmodule // spc_far_end
`default_nettype wire

// file: verification/spc_ctrl_chk.sv
// port-level properties of the sleep power controller
`timescale 1ns/1ns
`default_nettype none
module spc_ctrl_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic wait_for_interrupt_instr,
    input wire logic deep_sleep_select,
    input wire logic irq_pending,
    input wire logic sys_power_up_request,
    input wire logic debug_power_up_request,
    input wire logic core_power_en,
    input wire logic cpu_reset,
    input wire logic periph_reset,
    input wire logic cpu_idle,
    input wire logic rc_osc_enable,
    input wire logic debug_stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_idle_cause: assert property ($rose(cpu_idle) |-> $past(wait_for_interrupt_instr) && !$past(deep_sleep_select))
        else $error("idle sleep without shallow wfi");
    a_idle_exit: assert property (cpu_idle && irq_pending |=> !cpu_idle)
        else $error("interrupt did not end idle sleep");
    a_deep_held: assert property (!core_power_en |-> cpu_reset && periph_reset && debug_stall)
        else $error("core off without reset and stall");
    a_sys_blocks: assert property (sys_power_up_request [*6] |-> core_power_en)
        else $error("core off while system request set");
    a_dbg_emulates: assert property (debug_power_up_request [*6] |-> core_power_en)
        else $error("core off while debug request set");
    a_wake_reset: assert property ($rose(core_power_en) |-> cpu_reset [*8] ##1 cpu_reset ##1 cpu_reset ##1 !cpu_reset)
        else $error("cpu reset cycle length wrong");
    a_rc_deep_only: assert property (!rc_osc_enable |-> !core_power_en)
        else $error("rc oscillator off outside deep sleep");
    a_rc_restart: assert property ($rose(core_power_en) |-> rc_osc_enable)
        else $error("rc oscillator not restarted on wake");
endmodule // spc_ctrl_chk
bind spc_ctrl spc_ctrl_chk chk_u (.*);
`default_nettype wire

// file: verification/spc_ctrl_tb_top.sv
// self-checking bench for the sleep power controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", n, x, g); end end
module spc_ctrl_tb_top;
    import spc_pkg::*;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, irq_pending = 0;
    logic gpio_wake = 0, core_wake_write = 0, sleep_cmd = 0, deep_cmd = 0, txn = 0, txn_sys = 0;
    logic txn_dbg = 0, pready, pslverr, e, core_power_en, cpu_reset, periph_reset, cpu_idle;
    logic rc_osc_enable, debug_stall, wait_for_interrupt_instr, deep_sleep_select;
    logic sys_power_up_request, debug_power_up_request;
    logic [2:0] sleep_timer_wake = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r, v;
    logic [SPC_PERIPH_N-1:0] periph_clock_stop;
    logic [7:0] seed = 8'h2A;
    int n_mismatch = 0, checks = 0;
    spc_ctrl dut_u (.*);
    spc_far_end far_u (.*);
    always #50 clk = ~clk;
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] gate_exp(input logic [31:0] w);
        return w & 32'h0000_003F;
    endfunction
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        `CHK("ready", 1'h1, pready)
        if (pready !== 1'h1) close_out;
        @(posedge clk);
    endtask
    task automatic dbg_txn(input logic s, input logic d);
        txn <= 1'h1;
        txn_sys <= s;
        txn_dbg <= d;
        @(posedge clk);
        txn <= 1'h0;
        // leave room for the two-flop synchronisers
        repeat (4) @(posedge clk);
    endtask
    task automatic sleep(input logic d);
        sleep_cmd <= 1'h1;
        deep_cmd <= d;
        @(posedge clk);
        sleep_cmd <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic want(input logic [5:0] st);
        int i;
        i = 0;
        do begin
            apb(1'h0, SPC_STAT_ADDR, 32'h0);
            i++;
        end while (r[5:0] !== st && i < 60);
        `CHK("state", st, r[5:0])
        if (r[5:0] !== st) close_out;
    endtask
    initial begin
        int k;
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        apb(1'h0, SPC_GATE_ADDR, 32'h0);
        `CHK("gate reset", SPC_GATE_RST, r)
        `CHK("stop reset", 5'h00, periph_clock_stop)
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            apb(1'h0, SPC_GATE_ADDR, 32'h0);
            v = {26'h3FF_FFFF, r[5], (k == 0) ? 5'h1F : seed[4:0]};
            apb(1'h1, SPC_GATE_ADDR, v);
            `CHK("clock stop", v[4:0], periph_clock_stop)
            apb(1'h0, SPC_GATE_ADDR, 32'h0);
            `CHK("gate", gate_exp(v), r)
        end
        apb(1'h0, 32'h4000_4050, 32'h0);
        `CHK("unmapped err", 1'h1, e)
        `CHK("unmapped data", 32'h0, r)
        sleep(1'h0);
        `CHK("idle", 1'h1, cpu_idle)
        irq_pending <= 1'h1;
        repeat (2) @(posedge clk);
        `CHK("idle end", 1'h0, cpu_idle)
        irq_pending <= 1'h0;
        for (k = 0; k < 4; k++) begin
            apb(1'h1, SPC_CTRL_ADDR, 32'(k));
            dbg_txn(1'h1, 1'h0);
            sleep(1'h1);
            want(SPC_PRE);
            `CHK("pre power", 1'h1, core_power_en)
            `CHK("pre sys", 1'h1, r[SPC_STAT_SYS])
            dbg_txn(1'h0, 1'h0);
            want(SPC_DEEP);
            `CHK("deep power", 1'h0, core_power_en)
            `CHK("deep stall", 1'h1, debug_stall)
            `CHK("deep variant", k[0], r[SPC_STAT_DS2])
            `CHK("deep rc", ~k[0], rc_osc_enable)
            sleep_timer_wake <= 3'(1 << (k % 3));
            core_wake_write <= (k == 1);
            repeat (6) @(posedge clk);
            if (k == 1) begin
                want(SPC_DEEP);
                dbg_txn(1'h1, 1'h0);
            end
            want(SPC_RUN);
            `CHK("wake power", 1'h1, core_power_en)
            `CHK("wake reset", 1'h0, cpu_reset)
            `CHK("wake rc", 1'h1, rc_osc_enable)
            sleep_timer_wake <= 3'h0;
            core_wake_write <= 1'h0;
            dbg_txn(1'h0, 1'h0);
        end
        dbg_txn(1'h0, 1'h1);
        sleep(1'h1);
        want(SPC_EMU);
        `CHK("emu cpu", 1'h0, cpu_reset)
        `CHK("emu power", 1'h1, core_power_en)
        `CHK("emu dbg", 1'h1, r[SPC_STAT_DBG])
        `CHK("emu periph", 1'h1, periph_reset)
        core_wake_write <= 1'h1;
        @(posedge clk);
        core_wake_write <= 1'h0;
        want(SPC_RUN);
        dbg_txn(1'h1, 1'h0);
        sleep(1'h1);
        want(SPC_PRE);
        gpio_wake <= 1'h1;
        want(SPC_RUN);
        gpio_wake <= 1'h0;
        dbg_txn(1'h0, 1'h0);
        close_out;
    end
endmodule // spc_ctrl_tb_top
`default_nettype wire
